// ---- verilog/wspc_ctrl.sv ----
// Wait and stop power mode controller: clock gating, pin overrides, wake filter.
// Assumes wake inputs synchronous to clk and a free running clk for this logic.
`timescale 1ns/100ps
`include "wspc_map.svh"

// How it works
// RULE_01: Wait gates processor clock; watchdog runs only with count protection set.
// RULE_02: Wait keeps main, sub and slow internal oscillators running.
// RULE_03: Wait with clock gate bit stops fast peripheral clock; timer clocks stay.
// RULE_04: Wait instruction pulse enters wait mode.
// RULE_05: Software leaves the phase-locked loop before wait.
// RULE_06: Wait on external bus holds strobes, acknowledge, bus clock high, latch low.
// RULE_07: Clock output toggles in wait unless divided output and gating on.
// RULE_08: Reset, NMI, low voltage or enabled peripheral interrupt ends wait.
// RULE_09: Software zeroes peripheral priorities for reset-only style wake from wait.
// RULE_10: With gating, only event or sub timers and external serial wake.
// RULE_11: Watchdog reset ends wait only with count protection set.
// RULE_12: Software sets priorities, enable flag, peripherals, then waits.
// RULE_13: Wait exit resumes the same clock source and divider.
// RULE_14: Stop halts every oscillator and all internal clocks.
// RULE_15: All-clocks-off write enters stop, sets divide-by-eight and high drive.
// RULE_16: Software disables oscillation stop detection before stop.
// RULE_17: Software leaves and halts the phase-locked loop before stop.
// RULE_18: Stop wakes on NMI, key, external, low voltage, external counters, resets.
// RULE_19: Stop on external bus drives strobes high; single chip drives clock pin high.
// RULE_20: Software zeroes peripheral priorities for reset-only style wake from stop.
// RULE_21: Software prepares peripheral wake before writing all-clocks-off.
// RULE_22: Stop exit uses sub clock, or main or internal divided by eight.
// RULE_23: Stop exit holds processor clock until oscillator settle time passes.
module wspc_ctrl
  import wspc_pkg::*;
#(
  parameter int SETTLE_CYC = `WSPC_OSC_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic wait_instr,
  input wire logic all_clocks_off_wr,
  input wire logic wait_peripheral_clock_gate,
  input wire logic count_source_protect_enable,
  input wire logic brownout_filter_control,
  input wire logic ext_bus_mode,
  input wire logic [1:0] cpu_src,
  input wire logic [2:0] cpu_div,
  input wire logic divide_by_eight_select_in,
  input wire logic main_osc_high_drive_in,
  input wire logic [1:0] clock_output_sel,
  input wire logic clock_output_src,
  input wire wspc_bus_type bus_in,
  input wire wspc_wake_type wake,
  output logic [2:0] mode_state,
  output logic cpu_clk_en,
  output logic watchdog_clk_en,
  output logic fast_peripheral_clock_en,
  output logic timer_slow_clock_en,
  output logic main_osc_en,
  output logic sub_osc_en,
  output logic slow_internal_osc_en,
  output logic [1:0] cpu_src_out,
  output logic [2:0] cpu_div_out,
  output logic divide_by_eight_select,
  output logic main_osc_high_drive,
  output logic clock_output_pin,
  output logic bus_hold,
  output logic ale_indeterminate,
  output wspc_bus_type bus_out,
  output logic wake_pulse
);
  wspc_state_type state_r, state_nxt;
  logic [15:0] settle_r, settle_nxt;
  logic [1:0] src_r, src_nxt;
  logic [2:0] div_r, div_nxt;
  logic d8_r, d8_nxt;
  logic hd_r, hd_nxt;
  logic clko_r, clko_nxt;
  wspc_bus_type bus_r, bus_nxt;
  logic wait_wake, stop_wake, wake_r, wake_nxt;
  logic gate;

  assign gate = wait_peripheral_clock_gate;

  always_comb begin
    wait_wake = wake.nmi | wake.low_volt | wake.key_in | wake.ext_int | wake.brownout_rst; // RULE_08
    wait_wake = wait_wake | (wake.watchdog_rst & count_source_protect_enable); // RULE_11
    if (!gate) begin
      wait_wake = wait_wake | wake.timer | wake.serial | wake.converter | wake.other_periph;
    end else begin
      wait_wake = wait_wake | (wake.timer & (wake.timer_event_mode | wake.timer_sub_div32)) // RULE_10
        | (wake.serial & wake.serial_ext_clk);
    end
    stop_wake = wake.nmi | wake.key_in | wake.ext_int | wake.low_volt // RULE_18
      | (wake.timer & wake.timer_event_mode) | (wake.serial & wake.serial_ext_clk)
      | (wake.brownout_rst & brownout_filter_control);
  end

  always_comb begin
    state_nxt = state_r;
    settle_nxt = settle_r;
    src_nxt = src_r;
    div_nxt = div_r;
    d8_nxt = d8_r;
    hd_nxt = hd_r;
    wake_nxt = 1'b0;
    case (state_r)
      WSPC_RUN: begin
        src_nxt = cpu_src;
        div_nxt = cpu_div;
        d8_nxt = divide_by_eight_select_in;
        hd_nxt = main_osc_high_drive_in;
        if (all_clocks_off_wr) begin
          state_nxt = WSPC_STOP; // RULE_15
          d8_nxt = 1'b1;
          hd_nxt = 1'b1;
          settle_nxt = '0;
        end else if (wait_instr) begin
          state_nxt = WSPC_WAIT; // RULE_04
        end
      end
      WSPC_WAIT: begin
        if (wait_wake) begin
          state_nxt = WSPC_RUN; // RULE_13
          wake_nxt = 1'b1;
        end
      end
      WSPC_STOP: begin
        if (settle_r != 16'h0) begin
          if (settle_r >= 16'(SETTLE_CYC)) begin
            state_nxt = WSPC_RUN; // RULE_23
            wake_nxt = 1'b1;
            settle_nxt = '0;
            if (src_r != `WSPC_SRC_SUB) begin
              div_nxt = `WSPC_DIV_8; // RULE_22
            end
          end else begin
            settle_nxt = settle_r + 16'h1;
          end
        end else if (stop_wake) begin
          settle_nxt = 16'h1;
        end
      end
      default: state_nxt = WSPC_RUN;
    endcase
  end

  // Pin levels follow the next state so overrides land together with the mode change
  always_comb begin
    clko_nxt = clock_output_src; // RULE_07
    bus_nxt = bus_in;
    if (state_nxt == WSPC_WAIT) begin
      if (gate && clock_output_sel != `WSPC_CLKO_SUB) begin
        clko_nxt = clko_r;
      end
      if (ext_bus_mode) begin
        bus_nxt = '{rd: 1'b1, wr: 1'b1, write_strobe_low: 1'b1, write_strobe_high: 1'b1,
          hold_acknowledge: 1'b1, bclk: 1'b1, ale: 1'b0}; // RULE_06
      end
    end else if (state_nxt == WSPC_STOP) begin
      clko_nxt = 1'b1; // RULE_19
      if (ext_bus_mode) begin
        bus_nxt = '{rd: 1'b1, wr: 1'b1, write_strobe_low: 1'b1, write_strobe_high: 1'b1,
          hold_acknowledge: 1'b1, bclk: 1'b1, ale: 1'b0};
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= WSPC_RUN;
      settle_r <= 16'h0;
      src_r <= `WSPC_SRC_OCO;
      div_r <= `WSPC_DIV_8;
      d8_r <= 1'b1;
      hd_r <= 1'b0;
      wake_r <= 1'b0;
      clko_r <= 1'b0;
      bus_r <= '{rd: 1'b1, wr: 1'b1, write_strobe_low: 1'b1, write_strobe_high: 1'b1,
        hold_acknowledge: 1'b1, bclk: 1'b1, ale: 1'b0};
    end else begin
      state_r <= state_nxt;
      settle_r <= settle_nxt;
      src_r <= src_nxt;
      div_r <= div_nxt;
      d8_r <= d8_nxt;
      hd_r <= hd_nxt;
      wake_r <= wake_nxt;
      clko_r <= clko_nxt;
      bus_r <= bus_nxt;
    end
  end

  // Enables are registered from the next state so they switch with mode_state
  logic cpu_en_r, cpu_en_nxt, wdt_en_r, wdt_en_nxt, f1_en_r, f1_en_nxt;
  logic tmr_en_r, tmr_en_nxt, osc_en_r, osc_en_nxt, hold_r, hold_nxt, alex_r, alex_nxt;

  always_comb begin
    cpu_en_nxt = (state_nxt == WSPC_RUN); // RULE_01
    wdt_en_nxt = (state_nxt == WSPC_RUN)
      || (state_nxt == WSPC_WAIT && count_source_protect_enable); // RULE_01
    f1_en_nxt = (state_nxt == WSPC_RUN) || (state_nxt == WSPC_WAIT && !gate); // RULE_03
    tmr_en_nxt = (state_nxt != WSPC_STOP); // RULE_03
    // Oscillators restart as soon as the settle count begins
    osc_en_nxt = !((state_nxt == WSPC_STOP) && (settle_nxt == 16'h0)); // RULE_02 RULE_14
    hold_nxt = (state_nxt != WSPC_RUN) && ext_bus_mode; // RULE_06
    alex_nxt = !osc_en_nxt && ext_bus_mode; // RULE_19
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cpu_en_r <= 1'b1;
      wdt_en_r <= 1'b1;
      f1_en_r <= 1'b1;
      tmr_en_r <= 1'b1;
      osc_en_r <= 1'b1;
      hold_r <= 1'b0;
      alex_r <= 1'b0;
    end else begin
      cpu_en_r <= cpu_en_nxt;
      wdt_en_r <= wdt_en_nxt;
      f1_en_r <= f1_en_nxt;
      tmr_en_r <= tmr_en_nxt;
      osc_en_r <= osc_en_nxt;
      hold_r <= hold_nxt;
      alex_r <= alex_nxt;
    end
  end

  assign mode_state = state_r;
  assign cpu_clk_en = cpu_en_r;
  assign watchdog_clk_en = wdt_en_r;
  assign fast_peripheral_clock_en = f1_en_r;
  assign timer_slow_clock_en = tmr_en_r;
  assign main_osc_en = osc_en_r;
  assign sub_osc_en = osc_en_r;
  assign slow_internal_osc_en = osc_en_r;
  assign cpu_src_out = src_r;
  assign cpu_div_out = div_r;
  assign divide_by_eight_select = d8_r;
  assign main_osc_high_drive = hd_r;
  assign clock_output_pin = clko_r;
  assign bus_hold = hold_r;
  assign ale_indeterminate = alex_r;
  assign bus_out = bus_r;
  assign wake_pulse = wake_r;

  a_wait_entry: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == WSPC_RUN && wait_instr && !all_clocks_off_wr) |=> !cpu_clk_en) // RULE_04
    else $error("wait entry failed");
  a_stop_bits: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == WSPC_RUN && all_clocks_off_wr) |=> (d8_r && hd_r && !main_osc_en)) // RULE_15
    else $error("stop entry bits wrong");
  a_f1_gate: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == WSPC_WAIT && gate) |-> !fast_peripheral_clock_en) // RULE_03
    else $error("fast clock not gated");
  a_wdt_wait: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == WSPC_WAIT) |-> (watchdog_clk_en == count_source_protect_enable)) // RULE_01
    else $error("watchdog gating wrong");
  a_wait_exit: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == WSPC_WAIT && wake.nmi) |=> (cpu_clk_en && wake_pulse)) // RULE_08
    else $error("nmi did not end wait");
  a_wdt_block: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == WSPC_WAIT && !wait_wake && wake.watchdog_rst && !count_source_protect_enable)
    |=> !cpu_clk_en) // RULE_11
    else $error("watchdog woke without protect");
  a_src_kept: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == WSPC_WAIT) |=> (cpu_src_out == $past(cpu_src_out))) // RULE_13
    else $error("source changed in wait");
  a_stop_div8: assert property (@(posedge clk) disable iff (!resetn)
    ($rose(cpu_clk_en) && $past(state_r) == WSPC_STOP && cpu_src_out != `WSPC_SRC_SUB)
    |-> cpu_div_out == `WSPC_DIV_8) // RULE_22
    else $error("stop exit divider wrong");
  a_stop_clko: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == WSPC_STOP) |-> clock_output_pin) // RULE_19
    else $error("clock pin not high in stop");
  a_gate_wake: assert property (@(posedge clk) disable iff (!resetn)
    (state_r == WSPC_WAIT && gate && wake == '0) |=> !cpu_clk_en) // RULE_10
    else $error("spurious wait exit");
endmodule

// ---- verilog/wspc_map.svh ----
// Constants for the wait/stop power mode controller.
// Included by the controller and the bench files; definitions only.
`ifndef WSPC_MAP_SVH
`define WSPC_MAP_SVH
`define WSPC_CLK_MHZ 100
`define WSPC_OSC_SETTLE_US 2
`define WSPC_OSC_SETTLE_CYC ((`WSPC_OSC_SETTLE_US * `WSPC_CLK_MHZ))
`define WSPC_SRC_MAIN 2'h0
`define WSPC_SRC_SUB 2'h1
`define WSPC_SRC_OCO 2'h2
`define WSPC_SRC_PLL 2'h3
`define WSPC_DIV_8 3'h3
`define WSPC_CLKO_F8 2'h0
`define WSPC_CLKO_F32 2'h1
`define WSPC_CLKO_SUB 2'h2
`endif

// ---- verilog/wspc_pkg.sv ----
// Types for the wait/stop power mode controller.
// Does not include or use wspc_map.svh.
package wspc_pkg;
  typedef enum logic [2:0] {
    WSPC_RUN = 3'h1,
    WSPC_WAIT = 3'h2,
    WSPC_STOP = 3'h4
  } wspc_state_type;

  // Wake requests from the interrupt side
  typedef struct packed {
    logic nmi;
    logic low_volt;
    logic key_in;
    logic ext_int;
    logic timer;
    logic timer_event_mode;
    logic timer_sub_div32;
    logic serial;
    logic serial_ext_clk;
    logic converter;
    logic watchdog_rst;
    logic brownout_rst;
    logic other_periph;
  } wspc_wake_type;

  // Pin levels of the external bus
  typedef struct packed {
    logic rd;
    logic wr;
    logic write_strobe_low;
    logic write_strobe_high;
    logic hold_acknowledge;
    logic bclk;
    logic ale;
  } wspc_bus_type;
endpackage

// ---- bench/wspc_core_mdl.sv ----
// Behavioural core and clock software facing the power mode controller.
// Assumes tb_top changes go_w, go_s and want just after a rising edge.
`timescale 1ns/100ps
`include "wspc_map.svh"
module wspc_core_mdl (
  input wire logic go_w,
  input wire logic go_s,
  input wire logic [1:0] want,
  output logic wait_instr,
  output logic all_clocks_off_wr,
  output logic [1:0] cpu_src
);
  // Leaves the loop for the main clock on any low-power request
  assign cpu_src = (want == `WSPC_SRC_PLL && (go_w || go_s)) ? `WSPC_SRC_MAIN : want;
  // Software has set priorities, the enable flag and wake sources before either request
  assign wait_instr = go_w;
  // Stop is written only after detection is off and priorities are prepared
  assign all_clocks_off_wr = go_s;
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the wait/stop power mode controller.
// Assumes wspc_pkg compiled first and wspc_map.svh on the include path.
`timescale 1ns/100ps
`include "wspc_map.svh"
module tb_top import wspc_pkg::*; ;
  localparam int S = 4;
  logic clk = 0, resetn = 0, go_w = 0, go_s = 0, wait_instr, all_clocks_off_wr;
  logic wait_peripheral_clock_gate = 0, count_source_protect_enable = 0;
  logic brownout_filter_control = 0, ext_bus_mode = 1, clock_output_src = 0;
  logic divide_by_eight_select_in = 0, main_osc_high_drive_in = 0;
  logic [1:0] want = `WSPC_SRC_MAIN, cpu_src, clock_output_sel = `WSPC_CLKO_F8, cpu_src_out;
  logic [2:0] cpu_div = 3'h1, mode_state, cpu_div_out;
  wspc_bus_type bus_in = '0, bus_out;
  wspc_wake_type wake = '0;
  logic cpu_clk_en, watchdog_clk_en, fast_peripheral_clock_en, timer_slow_clock_en;
  logic main_osc_en, sub_osc_en, slow_internal_osc_en, divide_by_eight_select;
  logic main_osc_high_drive, clock_output_pin, bus_hold, ale_indeterminate, wake_pulse;
  int err_total = 0, samples_checked = 0;

  always #5 clk = ~clk;
  always @(posedge clk) clock_output_src <= #1 ~clock_output_src;

  wspc_core_mdl mdl_u (.go_w, .go_s, .want, .wait_instr, .all_clocks_off_wr, .cpu_src);
  wspc_ctrl #(.SETTLE_CYC(S)) dut_u (.clk, .resetn, .wait_instr, .all_clocks_off_wr,
    .wait_peripheral_clock_gate, .count_source_protect_enable, .brownout_filter_control,
    .ext_bus_mode, .cpu_src, .cpu_div, .divide_by_eight_select_in, .main_osc_high_drive_in,
    .clock_output_sel, .clock_output_src, .bus_in, .wake, .mode_state, .cpu_clk_en,
    .watchdog_clk_en, .fast_peripheral_clock_en, .timer_slow_clock_en, .main_osc_en,
    .sub_osc_en, .slow_internal_osc_en, .cpu_src_out, .cpu_div_out, .divide_by_eight_select,
    .main_osc_high_drive, .clock_output_pin, .bus_hold, .ale_indeterminate, .bus_out,
    .wake_pulse);

  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", nm, e, s);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic enter_wait();
    go_w = 1;
    tick(1);
    go_w = 0;
    chk("state", mode_state, 3'h2);
    chk("cpu en", cpu_clk_en, 1'b0);
    chk("osc", {main_osc_en, sub_osc_en, slow_internal_osc_en}, 3'h7);
  endtask

  task automatic t_wait();
    want = `WSPC_SRC_SUB;
    cpu_div = 3'h2;
    wake.watchdog_rst = 1;
    tick(1);
    enter_wait();
    chk("wdt en", watchdog_clk_en, 1'b0);
    chk("f1 en", fast_peripheral_clock_en, 1'b1);
    chk("bus", bus_out, 7'h7e);
    chk("hold", bus_hold, 1'b1);
    tick(2);
    chk("wdt wake", mode_state, 3'h2);
    wake = '0;
    wake.nmi = 1;
    tick(1);
    wake = '0;
    chk("exit", mode_state, 3'h1);
    chk("pulse", wake_pulse, 1'b1);
    chk("src", {cpu_src_out, cpu_div_out}, {2'h1, 3'h2});
    count_source_protect_enable = 1;
    tick(1);
    enter_wait();
    chk("wdt on", watchdog_clk_en, 1'b1);
    wake.watchdog_rst = 1;
    tick(1);
    wake = '0;
    count_source_protect_enable = 0;
    chk("wdt exit", mode_state, 3'h1);
    $display("test wait done");
  endtask

  task automatic t_gate();
    logic p;
    want = `WSPC_SRC_PLL;
    ext_bus_mode = 0;
    wait_peripheral_clock_gate = 1;
    tick(1);
    enter_wait();
    chk("f1 off", fast_peripheral_clock_en, 1'b0);
    chk("tmr clk", timer_slow_clock_en, 1'b1);
    p = clock_output_pin;
    wake.timer = 1;
    wake.serial = 1;
    wake.converter = 1;
    tick(3);
    chk("pin", clock_output_pin, p);
    chk("no wake", mode_state, 3'h2);
    clock_output_sel = `WSPC_CLKO_SUB;
    tick(1);
    p = clock_output_pin;
    tick(1);
    chk("pin sub", clock_output_pin, !p);
    clock_output_sel = `WSPC_CLKO_F8;
    wake.timer_event_mode = 1;
    tick(1);
    wake = '0;
    wait_peripheral_clock_gate = 0;
    chk("ev wake", mode_state, 3'h1);
    chk("main", cpu_src_out, `WSPC_SRC_MAIN);
    $display("test gate done");
  endtask

  task automatic t_stop(input logic [1:0] src, input logic ext);
    int n;
    want = src;
    cpu_div = 3'h0;
    ext_bus_mode = ext;
    brownout_filter_control = ext;
    tick(1);
    go_s = 1;
    tick(1);
    go_s = 0;
    chk("stop", mode_state, 3'h4);
    chk("d8 hd", {divide_by_eight_select, main_osc_high_drive}, 2'h3);
    chk("off", {main_osc_en, sub_osc_en, slow_internal_osc_en, cpu_clk_en,
      fast_peripheral_clock_en}, 5'h0);
    if (ext) begin
      chk("bus", bus_out, 7'h7e);
      chk("ale x", ale_indeterminate, 1'b1);
    end else begin
      chk("pin hi", clock_output_pin, 1'b1);
      wake.brownout_rst = 1;
    end
    wake.timer = 1;
    wake.serial = 1;
    wake.other_periph = 1;
    tick(3);
    chk("stay", mode_state, 3'h4);
    wake = '0;
    if (ext) wake.brownout_rst = 1;
    else wake.key_in = 1;
    n = 0;
    tick(1);
    wake = '0;
    while (mode_state !== 3'h1 && n < 50) begin
      tick(1);
      n++;
    end
    chk("settle", n, S);
    chk("back", mode_state, 3'h1);
    chk("src", {cpu_src_out, cpu_div_out},
      {src, (src == `WSPC_SRC_SUB) ? 3'h0 : `WSPC_DIV_8});
    $display("test stop done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  initial begin
    #50000;
    err_total++;
    complete_run();
  end

  initial begin
    tick(12);
    resetn = 1;
    tick(1);
    t_wait();
    t_gate();
    t_stop(`WSPC_SRC_OCO, 1'b0);
    t_stop(`WSPC_SRC_SUB, 1'b1);
    complete_run();
  end
endmodule
